// ==== rtl/exec_unit_pkg.sv ====
// Summary of operation
// RULE_01: Literal add sums accumulator and immediate, all flags.
// RULE_02: Literal AND updates accumulator, zero flag only.
// RULE_03: File add sums accumulator and file, all flags.
// RULE_04: File AND with accumulator, zero flag only.
// RULE_05: Destination bit selects accumulator or file register.
// RULE_06: File forms: decode, read, compute, write phases.
// RULE_07: Literal forms: decode, read, compute, write accumulator.
// RULE_08: Carry bit7, nibble carry bit3, zero on zero.
package exec_unit_pkg;

  // ----------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------
  localparam int          INSN_WIDTH     = 14;
  localparam int          DATA_WIDTH     = 8;
  localparam int          ADDR_WIDTH     = 7;
  localparam int          DEST_BIT       = 7;
  localparam logic [5:0]  OPC_ADD_IMM    = 6'h3e;
  localparam logic [5:0]  OPC_ADD_IMM_M  = 6'h3e;
  localparam logic [5:0]  OPC_AND_IMM    = 6'h39;
  localparam logic [5:0]  OPC_ADD_FILE   = 6'h07;
  localparam logic [5:0]  OPC_AND_FILE   = 6'h05;
  localparam logic [7:0]  ACC_RESET      = 8'h00;
  localparam logic [1:0]  PHASE_COUNT    = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PH_DECODE  = 4'b0001,
    PH_READ    = 4'b0010,
    PH_PROCESS = 4'b0100,
    PH_WRITE   = 4'b1000
  } phase_type;

  typedef enum logic [3:0] {
    OP_NONE     = 4'b0000,
    OP_ADD_IMM  = 4'b0001,
    OP_AND_IMM  = 4'b0010,
    OP_ADD_FILE = 4'b0100,
    OP_AND_FILE = 4'b1000
  } op_type;

  typedef struct packed {
    logic carry;
    logic nibble_carry_flag;
    logic zero;
  } flags_type;

  typedef struct packed {
    logic       en;
    logic [6:0] addr;
    logic [7:0] data;
  } file_wr_type;

  typedef struct packed {
    logic [7:0] result;
    flags_type  flags;
    logic       carry_upd;
  } alu_out_type;

endpackage

// ==== rtl/exec_alu.sv ====
module exec_alu
  import exec_unit_pkg::*;
(
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       do_add,
  output alu_out_type     y
);

  logic [4:0] low_sum;
  logic [8:0] full_sum;

  always_comb begin
    low_sum  = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    full_sum = {1'b0, a} + {1'b0, b};
    y.carry_upd = do_add;
    if (do_add) begin
      y.result = full_sum[7:0];
    end else begin
      y.result = a & b;
    end
    y.flags.carry             = full_sum[8];  // RULE_08
    y.flags.nibble_carry_flag = low_sum[4];   // RULE_08
    y.flags.zero              = (y.result == 8'h00);  // RULE_08
  end

endmodule

// ==== rtl/add_and_execute_unit.sv ====
module add_and_execute_unit
  import exec_unit_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic        INSN_VALID,
  input  wire logic [13:0] INSN,
  input  wire logic [7:0]  FILE_RDATA,
  output logic             INSN_READY,
  output logic [6:0]       FILE_ADDR,
  output logic             FILE_RD,
  output file_wr_type      FILE_WR,
  output logic [7:0]       ACC,
  output flags_type        FLAGS,
  output logic [3:0]       PHASE,
  output logic             DONE,
  output logic             ILLEGAL
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  phase_type   phase_q, phase_d;
  op_type      op_q, op_d;
  logic [13:0] insn_q, insn_d;
  logic [7:0]  opnd_q, opnd_d;
  alu_out_type res_q, res_d;
  logic [7:0]  acc_q, acc_d;
  flags_type   flags_q, flags_d;
  file_wr_type wr_q, wr_d;
  logic        rd_q, rd_d;
  logic        done_q, done_d;
  logic        ill_q, ill_d;
  logic        rdy_q, rdy_d;
  logic [6:0]  addr_q, addr_d;
  alu_out_type alu_y;
  logic        is_add;

  assign is_add = (op_q == OP_ADD_IMM) || (op_q == OP_ADD_FILE);

  exec_alu u_alu (
    .a      (acc_q),
    .b      (opnd_q),
    .do_add (is_add),
    .y      (alu_y)
  );

  // ----------------------------------------------------------------
  // Phase sequencer and datapath
  // ----------------------------------------------------------------
  always_comb begin
    phase_d = phase_q;
    op_d    = op_q;
    insn_d  = insn_q;
    opnd_d  = opnd_q;
    res_d   = res_q;
    acc_d   = acc_q;
    flags_d = flags_q;
    wr_d    = '0;
    rd_d    = 1'b0;
    done_d  = 1'b0;
    ill_d   = 1'b0;
    rdy_d   = 1'b0;
    addr_d  = addr_q;
    case (phase_q)
      PH_DECODE: begin
        rdy_d = 1'b1;
        if (INSN_VALID && rdy_q) begin
          rdy_d  = 1'b0;
          insn_d = INSN;
          addr_d = INSN[ADDR_WIDTH-1:0];
          // Decode happens in the first phase of every form.
          if ((INSN[13:8] & OPC_ADD_IMM_M) == OPC_ADD_IMM) begin
            op_d = OP_ADD_IMM;  // RULE_01
          end else if (INSN[13:8] == OPC_AND_IMM) begin
            op_d = OP_AND_IMM;  // RULE_02
          end else if (INSN[13:8] == OPC_ADD_FILE) begin
            op_d = OP_ADD_FILE;  // RULE_03
            rd_d = 1'b1;
          end else if (INSN[13:8] == OPC_AND_FILE) begin
            op_d = OP_AND_FILE;  // RULE_04
            rd_d = 1'b1;
          end else begin
            op_d = OP_NONE;
          end
          phase_d = PH_READ;
        end
      end
      PH_READ: begin
        // Operand read: immediate or file data.
        if (op_q == OP_ADD_IMM || op_q == OP_AND_IMM) begin
          opnd_d = insn_q[7:0];  // RULE_07
        end else begin
          opnd_d = FILE_RDATA;  // RULE_06
        end
        phase_d = PH_PROCESS;
      end
      PH_PROCESS: begin
        res_d   = alu_y;  // RULE_06
        phase_d = PH_WRITE;
      end
      PH_WRITE: begin
        done_d  = 1'b1;
        phase_d = PH_DECODE;
        if (op_q == OP_NONE) begin
          ill_d = 1'b1;
        end else begin
          flags_d.zero = res_q.flags.zero;  // RULE_02
          if (res_q.carry_upd) begin
            flags_d = res_q.flags;  // RULE_08
          end
          if ((op_q == OP_ADD_FILE || op_q == OP_AND_FILE) && insn_q[DEST_BIT]) begin
            wr_d.en   = 1'b1;  // RULE_05
            wr_d.addr = addr_q;
            wr_d.data = res_q.result;
          end else begin
            acc_d = res_q.result;  // RULE_05
          end
        end
      end
      default: begin
        phase_d = PH_DECODE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      phase_q <= PH_DECODE;
      op_q    <= OP_NONE;
      insn_q  <= '0;
      opnd_q  <= 8'h00;
      res_q   <= '0;
      acc_q   <= ACC_RESET;
      flags_q <= '0;
      wr_q    <= '0;
      rd_q    <= 1'b0;
      done_q  <= 1'b0;
      ill_q   <= 1'b0;
      rdy_q   <= 1'b0;
      addr_q  <= 7'h00;
    end else begin
      phase_q <= phase_d;
      op_q    <= op_d;
      insn_q  <= insn_d;
      opnd_q  <= opnd_d;
      res_q   <= res_d;
      acc_q   <= acc_d;
      flags_q <= flags_d;
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      done_q  <= done_d;
      ill_q   <= ill_d;
      rdy_q   <= rdy_d;
      addr_q  <= addr_d;
    end
  end

  assign INSN_READY = rdy_q;
  assign FILE_ADDR  = addr_q;
  assign FILE_RD    = rd_q;
  assign FILE_WR    = wr_q;
  assign ACC        = acc_q;
  assign FLAGS      = flags_q;
  assign PHASE      = phase_q;
  assign DONE       = done_q;
  assign ILLEGAL    = ill_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  sequence s_take;
    INSN_VALID && INSN_READY;
  endsequence

  sequence s_add_imm;
    s_take ##0 ((INSN[13:8] & OPC_ADD_IMM_M) == OPC_ADD_IMM);
  endsequence

  a_add_imm_sum: assert property ( // RULE_01
    s_add_imm |-> ##4 (ACC == 8'($past(ACC, 4) + $past(INSN[7:0], 4))))
    else $error("literal add result wrong");

  a_and_imm_res: assert property ( // RULE_02
    (s_take ##0 INSN[13:8] == OPC_AND_IMM) |->
      ##4 (ACC == ($past(ACC, 4) & $past(INSN[7:0], 4)) && FLAGS.carry == $past(FLAGS.carry, 4)))
    else $error("literal and result wrong");

  a_add_file_sum: assert property ( // RULE_03
    (s_take ##0 INSN[13:8] == OPC_ADD_FILE && !INSN[DEST_BIT]) |->
      ##4 (ACC == 8'($past(ACC, 4) + $past(FILE_RDATA, 3))))
    else $error("file add result wrong");

  a_and_file_flag: assert property ( // RULE_04
    (s_take ##0 INSN[13:8] == OPC_AND_FILE) |->
      ##4 (FLAGS.nibble_carry_flag == $past(FLAGS.nibble_carry_flag, 4)))
    else $error("file and touched carries");

  a_dest_file: assert property ( // RULE_05
    (s_take ##0 (INSN[13:8] == OPC_ADD_FILE || INSN[13:8] == OPC_AND_FILE) && INSN[DEST_BIT]) |->
      ##4 (FILE_WR.en && ACC == $past(ACC, 4)))
    else $error("destination file write wrong");

  a_four_phase: assert property ( // RULE_06
    s_take |-> ##1 PHASE == PH_READ ##1 PHASE == PH_PROCESS ##1 PHASE == PH_WRITE ##1 DONE)
    else $error("phase order wrong");

  a_file_read: assert property ( // RULE_06
    FILE_RD |-> PHASE == PH_READ)
    else $error("file read outside read phase");

  a_one_cycle: assert property ( // RULE_07
    s_take |-> ##4 (DONE && INSN_READY == 1'b0) ##1 INSN_READY)
    else $error("instruction not one cycle");

  a_zero_flag: assert property ( // RULE_08
    (DONE && !ILLEGAL && !$past(FILE_WR.en)) |-> (FLAGS.zero == (ACC == 8'h00)) or FILE_WR.en)
    else $error("zero flag wrong");

endmodule

// ==== bench/add_and_execute_unit_test.sv ====
module add_and_execute_unit_test
  import exec_unit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk;
  logic        rst;
  logic        insn_valid;
  logic [13:0] insn;
  logic [7:0]  file_rdata;
  logic        insn_ready;
  logic [6:0]  file_addr;
  logic        file_rd;
  file_wr_type file_wr;
  logic [7:0]  acc;
  flags_type   flags;
  logic [3:0]  phase;
  logic        done;
  logic        illegal;
  logic [7:0]  acc_m;
  flags_type   flags_m;
  int          miscompares = 0;
  int          n_checks = 0;

  add_and_execute_unit DUT (
    .SYS_CLK    (sys_clk),
    .RST        (rst),
    .INSN_VALID (insn_valid),
    .INSN       (insn),
    .FILE_RDATA (file_rdata),
    .INSN_READY (insn_ready),
    .FILE_ADDR  (file_addr),
    .FILE_RD    (file_rd),
    .FILE_WR    (file_wr),
    .ACC        (acc),
    .FLAGS      (flags),
    .PHASE      (phase),
    .DONE       (done),
    .ILLEGAL    (illegal)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_flags(input flags_type exp, input flags_type got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch flags expected %b seen %b", exp, got);
    end
  endtask

  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic timeout(input string what);
    miscompares++;
    $display("mismatch %s expected high seen timeout", what);
    give_verdict();
  endtask

  // Runs one instruction and checks every result against the bench's own model.
  task automatic exec(input logic [13:0] w, input logic [7:0] fd);
    logic [5:0] op;
    logic       file;
    logic       add;
    logic       legal;
    logic       to_file;
    logic [7:0] b;
    logic [7:0] res;
    logic [8:0] sum;
    int         n;
    op = w[13:8];
    file = (op == OPC_ADD_FILE) || (op == OPC_AND_FILE);
    add = (op == OPC_ADD_FILE) || (op[5:1] == OPC_ADD_IMM[5:1]);
    legal = file || add || (op == OPC_AND_IMM);
    b = file ? fd : w[7:0];
    sum = {1'b0, acc_m} + {1'b0, b};
    res = add ? sum[7:0] : (acc_m & b);
    to_file = legal && file && w[DEST_BIT];
    insn = w;
    file_rdata = fd;
    insn_valid = 1'b1;
    n = 0;
    while (insn_ready !== 1'b1) begin
      step();
      n++;
      if (n > 20) timeout("insn_ready");
    end
    step();
    insn_valid = 1'b0;
    chk_val("ready", 16'h0, 16'(insn_ready));
    if (legal) begin
      chk_val("phase", 16'h2, 16'(phase));
      chk_val("file_rd", 16'(file), 16'(file_rd));
      if (file) chk_val("file_addr", 16'(w[6:0]), 16'(file_addr));
    end
    n = 0;
    while (done !== 1'b1) begin
      step();
      n++;
      if (n > 4) timeout("done");
    end
    file_rdata = ~fd;
    if (legal) begin
      if (add) begin
        flags_m.carry = sum[8];
        flags_m.nibble_carry_flag = ({1'b0, acc_m[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
      end
      flags_m.zero = (res == 8'h00);
      if (!to_file) acc_m = res;
    end
    chk_val("acc", 16'(acc_m), 16'(acc));
    chk_flags(flags_m, flags);
    chk_val("file_wr_en", 16'(to_file), 16'(file_wr.en));
    if (to_file) chk_val("file_wr", {1'b0, w[6:0], res}, {1'b0, file_wr.addr, file_wr.data});
    chk_val("illegal", 16'(!legal), 16'(illegal));
  endtask

  task automatic t_add_imm();
    exec({6'h3e, 8'h10}, 8'h00);
    exec({6'h3e, 8'h15}, 8'h00);
    exec({6'h3f, 8'hdb}, 8'h00);
    exec({6'h3f, 8'h0f}, 8'h00);
    exec({6'h3e, 8'h01}, 8'h00);
    $display("test add_imm done");
  endtask

  task automatic t_and_imm();
    exec({6'h3e, 8'h93}, 8'h00);
    exec({6'h39, 8'h5f}, 8'h00);
    exec({6'h3e, 8'hff}, 8'h00);
    exec({6'h39, 8'h00}, 8'h00);
    $display("test and_imm done");
  endtask

  task automatic t_file_ops();
    exec({6'h3e, 8'h17}, 8'h00);
    exec({6'h07, 1'b0, 7'h04}, 8'hc2);
    exec({6'h07, 1'b1, 7'h7f}, 8'h40);
    exec({6'h05, 1'b1, 7'h04}, 8'hc2);
    exec({6'h05, 1'b0, 7'h00}, 8'h26);
    exec({6'h00, 8'h80}, 8'h55);
    $display("test file_ops done");
  endtask

  initial begin
    rst = 1'b1;
    insn_valid = 1'b0;
    insn = 14'h0000;
    file_rdata = 8'h00;
    acc_m = ACC_RESET;
    flags_m = '0;
    repeat (8) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    chk_val("phase", 16'h1, 16'(phase));
    t_add_imm();
    t_and_imm();
    t_file_ops();
    give_verdict();
  end
endmodule
